/* pkg/serial_cfg.svh */
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH

// ============================================================
// Bit order selection
`define FIRST_BIT_LSB   1'b1
// ============================================================
// Transfer length and reset values
`define LAST_BIT_IDX    3'd7
`define SHIFT_RST       8'h00
`define CNT_RST         3'd0

`endif

/* pkg/serial_pkg.sv */
package serial_pkg;
  // ============================================================
  // Core-side transfer state.
  typedef enum logic {ST_IDLE, ST_BUSY} core_state_e;

  // One received byte on its way to the reader.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_word_s;
endpackage

/* rtl/clocked_serial_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg.svh"

// Behaviour
// [RL1] One mode bit picks whether the most or the least significant bit travels first.
// [RL2] Order is applied by reversing bits between bus and shift register on write and read, shifting stays MSB-first.
// [RL3] Software changes the first-bit choice only before writing the byte that is to be sent.
// [RL4] A write of the shift register starts a transfer only while the unit is enabled and idle.
// [RL5] A byte written while disabled does not start a transfer when the unit is enabled later.
// [RL6] After eight bits the transfer stops by itself and the done flag is set.
// [RL7] A write during a running transfer neither restarts nor disturbs it.
module clocked_serial_unit
  import serial_pkg::*;
(
  input  wire logic       ref_clk,             // Core clock, 250 MHz.
  input  wire logic       rst_n,               // Asynchronous reset, active low.
  input  wire logic       serial_unit_enable,  // Unit enable level.
  input  wire logic       first_bit_select,    // 1 selects LSB first.
  input  wire logic       wr_valid,            // Write strobe for the shift register.
  input  wire logic [7:0] wr_data,             // Byte to send.
  output logic            wr_ready,            // A write now would start a transfer if the unit is enabled.
  output logic            busy,                // Transfer in progress.
  input  wire logic       flag_clear,          // Clears the done flag.
  output logic            transfer_done_flag,  // Sticky transfer-complete request.
  output logic            rx_valid,            // Received byte available.
  output logic [7:0]      rx_data,             // Received byte, in bus order.
  input  wire logic       rx_ready,            // Reader takes the byte.
  input  wire logic       link_clk,            // Serial clock from the peer.
  input  wire logic       serial_in,           // Serial data from the peer.
  output logic            serial_out           // Serial data to the peer.
);

  // ============================================================
  // Helpers
  // Maps a byte between bus order and the fixed MSB-first shift order.
  function automatic logic [7:0] bus_order(input logic [7:0] d, input logic lsb_first);
    logic [7:0] r;
    r = d;
    if (lsb_first == `FIRST_BIT_LSB) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7-i];
      end
    end
    return r;
  endfunction

  // ============================================================
  // Link-domain reset release and start crossing
  logic       lrst1_r, lrst_n_r;
  logic       st1_r, st2_r, st3_r, st_seen_r;
  logic       start_tgl_r;
  logic [7:0] tx_hold_r;

  // Reset is released in step with the link clock so the shifter never starts half-reset.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst1_r  <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst1_r  <= 1'b1;
      lrst_n_r <= lrst1_r;
    end
  end

  // ============================================================
  // Link-domain shifter
  logic       run_r, run_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic       out_r, out_nxt;
  logic       done_tgl_r, done_tgl_nxt;
  logic       st_seen_nxt;
  logic       start_evt;

  // A toggle counts once the second and third stages agree.
  assign start_evt = (st2_r == st3_r) && (st3_r != st_seen_r);

  // The shift direction never changes; bit order was settled at the write.
  always_comb begin
    run_nxt      = run_r;
    cnt_nxt      = cnt_r;
    shreg_nxt    = shreg_r;
    out_nxt      = out_r;
    done_tgl_nxt = done_tgl_r;
    st_seen_nxt  = st_seen_r;
    if (start_evt) begin
      st_seen_nxt = st3_r;
      run_nxt     = 1'b1;
      cnt_nxt     = `CNT_RST;
      shreg_nxt   = tx_hold_r;  // Stable: the core holds it until done returns.
    end else if (run_r) begin
      out_nxt   = shreg_r[7];                    // RL2
      shreg_nxt = {shreg_r[6:0], serial_in};
      cnt_nxt   = cnt_r + 3'd1;
      if (cnt_r == `LAST_BIT_IDX) begin
        run_nxt      = 1'b0;                     // RL6
        done_tgl_nxt = ~done_tgl_r;              // RL6
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      st1_r      <= 1'b0;
      st2_r      <= 1'b0;
      st3_r      <= 1'b0;
      st_seen_r  <= 1'b0;
      run_r      <= 1'b0;
      cnt_r      <= `CNT_RST;
      shreg_r    <= `SHIFT_RST;
      out_r      <= 1'b0;
      done_tgl_r <= 1'b0;
    end else begin
      st1_r      <= start_tgl_r;
      st2_r      <= st1_r;
      st3_r      <= st2_r;
      st_seen_r  <= st_seen_nxt;
      run_r      <= run_nxt;
      cnt_r      <= cnt_nxt;
      shreg_r    <= shreg_nxt;
      out_r      <= out_nxt;
      done_tgl_r <= done_tgl_nxt;
    end
  end

  assign serial_out = out_r;

  // ============================================================
  // Core domain: start, completion and receive buffer
  logic        dn1_r, dn2_r, dn3_r, dn_seen_r, dn_seen_nxt;
  logic        done_evt, start, pop;
  core_state_e state_r, state_nxt;
  logic [7:0]  tx_hold_nxt;
  logic        start_tgl_nxt;
  logic        flag_r, flag_nxt;
  logic        wr_ready_r, wr_ready_nxt;
  rx_word_s    head_r, head_nxt, tail_r, tail_nxt;

  assign done_evt = (dn2_r == dn3_r) && (dn3_r != dn_seen_r);
  // Enable is sampled at the write itself, so a byte offered while disabled is simply dropped.
  assign start    = wr_valid && serial_unit_enable && wr_ready_r;  // RL4 RL5 RL7
  assign pop      = rx_ready && head_r.valid;

  // Starting needs a free buffer slot, so a stalled reader throttles new transfers instead of losing bytes.
  always_comb begin
    state_nxt     = state_r;
    tx_hold_nxt   = tx_hold_r;
    start_tgl_nxt = start_tgl_r;
    dn_seen_nxt   = dn_seen_r;
    flag_nxt      = flag_r & ~flag_clear;
    head_nxt      = head_r;
    tail_nxt      = tail_r;
    if (pop) begin
      head_nxt = tail_r;
      tail_nxt = '0;
    end
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt     = ST_BUSY;
          tx_hold_nxt   = bus_order(wr_data, first_bit_select);  // RL1 RL2
          start_tgl_nxt = ~start_tgl_r;
        end
      end
      ST_BUSY: begin
        if (done_evt) begin
          dn_seen_nxt = dn3_r;
          state_nxt   = ST_IDLE;
          flag_nxt    = 1'b1;  // RL6
          if (!head_nxt.valid) begin
            head_nxt = '{valid: 1'b1, data: bus_order(shreg_r, first_bit_select)};  // RL2
          end else begin
            tail_nxt = '{valid: 1'b1, data: bus_order(shreg_r, first_bit_select)};  // RL2
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    wr_ready_nxt = (state_nxt == ST_IDLE) && !tail_nxt.valid;  // RL7
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dn1_r       <= 1'b0;
      dn2_r       <= 1'b0;
      dn3_r       <= 1'b0;
      dn_seen_r   <= 1'b0;
      state_r     <= ST_IDLE;
      tx_hold_r   <= `SHIFT_RST;
      start_tgl_r <= 1'b0;
      flag_r      <= 1'b0;
      wr_ready_r  <= 1'b0;
      head_r      <= '0;
      tail_r      <= '0;
    end else begin
      dn1_r       <= done_tgl_r;
      dn2_r       <= dn1_r;
      dn3_r       <= dn2_r;
      dn_seen_r   <= dn_seen_nxt;
      state_r     <= state_nxt;
      tx_hold_r   <= tx_hold_nxt;
      start_tgl_r <= start_tgl_nxt;
      flag_r      <= flag_nxt;
      wr_ready_r  <= wr_ready_nxt;
      head_r      <= head_nxt;
      tail_r      <= tail_nxt;
    end
  end

  assign wr_ready           = wr_ready_r;
  assign busy               = (state_r == ST_BUSY);
  assign transfer_done_flag = flag_r;
  assign rx_valid           = head_r.valid;
  assign rx_data            = head_r.data;

  // ============================================================
  // Checks
  // Reference reversal built apart from bus_order, so a broken helper cannot hide behind its own copy.
  logic [7:0] wr_data_rev;
  assign wr_data_rev = {<<{wr_data}};

  sequence seq_lsb_write;
    wr_valid && serial_unit_enable && wr_ready_r && first_bit_select;
  endsequence

  // Eight shifting edges, then the shifter drops run and hands the done toggle over.
  sequence seq_eight_shifts;
    run_r [*8] ##1 (!run_r && $changed(done_tgl_r));
  endsequence

  AST_REVERSE_ON_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL1
    seq_lsb_write |=> (tx_hold_r == $past(wr_data_rev)))
    else $error("LSB-first write was not reversed into the shift register.");

  AST_ORDER_KEPT_MSB: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL2
    (start && !first_bit_select) |=> (tx_hold_r == $past(wr_data)))
    else $error("MSB-first write was altered on its way in.");

  AST_DISABLED_NO_START: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL4
    (state_r == ST_IDLE && !serial_unit_enable) |=> (state_r == ST_IDLE))
    else $error("Transfer started while the unit was disabled.");

  AST_LATE_ENABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL5
    (state_r == ST_IDLE && $rose(serial_unit_enable) && !wr_valid) |=> (state_r == ST_IDLE))
    else $error("Enabling the unit started a transfer without a write.");

  AST_DONE_SETS_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL6
    (state_r == ST_BUSY && done_evt) |=> (flag_r && state_r == ST_IDLE))
    else $error("Completion did not set the flag and return to idle.");

  AST_BUSY_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL7
    (state_r == ST_BUSY && wr_valid) |=> ($stable(tx_hold_r) && $stable(start_tgl_r)))
    else $error("Write during a transfer disturbed it.");

  AST_EIGHT_BITS: assert property (@(posedge link_clk) disable iff (!lrst_n_r)  // RL6
    (start_evt && !run_r) |=> seq_eight_shifts)
    else $error("Shifter did not stop after exactly eight bits.");

endmodule

`default_nettype wire

/* testbench/serial_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Peer that clocks the link and echoes every sent bit back.
module serial_peer_model (
  output logic      link_clk,   // Link clock, 12 ns.
  input  wire logic serial_out, // Bits from the unit.
  output logic      serial_in   // Echoed bits to the unit.
);
  // Offset start so link edges never line up with core edges.
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #6 link_clk = ~link_clk;
  end
  // Echo on the falling edge, so the unit samples a settled level.
  always_ff @(negedge link_clk) begin
    serial_in <= serial_out;
  end
endmodule
`default_nettype wire

/* testbench/test_clocked_serial_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench: looped-back link, received words checked against a queue.
module test_clocked_serial_unit
  import serial_pkg::*;
;
  logic        ref_clk, rst_n, serial_unit_enable, first_bit_select, wr_valid, flag_clear;
  logic        rx_ready, drain, wr_ready, busy, transfer_done_flag, rx_valid;
  logic        link_clk, serial_in, serial_out;
  logic [7:0]  wr_data, rx_data;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  int          err_count, checks;

  clocked_serial_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .serial_unit_enable(serial_unit_enable),
    .first_bit_select(first_bit_select), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .busy(busy), .flag_clear(flag_clear), .transfer_done_flag(transfer_done_flag), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .link_clk(link_clk), .serial_in(serial_in),
    .serial_out(serial_out));
  serial_peer_model peer_u (.link_clk(link_clk), .serial_out(serial_out), .serial_in(serial_in));

  task automatic check8(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test;
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Loopback echo lags one bit, so the last sent bit is lost and one end bit is masked.
  task automatic send(input logic [7:0] w, input logic go);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_data  <= w;
    @(posedge ref_clk);
    wr_valid <= 1'b0;
    if (go && first_bit_select) exp_q.push_back({8'hfe, w << 1});
    else if (go) exp_q.push_back({8'h7f, w >> 1});
  endtask

  task automatic wait_free(input logic need_ready);
    int n;
    n = 0;
    while ((busy !== 1'b0 || (need_ready && wr_ready !== 1'b1)) && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 1000) check8(8'h01, 8'h00);
  endtask

  task automatic wait_empty;
    for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge ref_clk);
    check8(8'(exp_q.size()), 8'h00);
  endtask

  // One transfer, a stray write into it, then the done flag set and cleared.
  task automatic xfer(input logic [7:0] w);
    wait_free(1'b1);
    send(w, 1'b1);
    @(posedge ref_clk);
    check8({7'h0, busy}, 8'h01);
    send(~w, 1'b0);
    wait_free(1'b0);
    @(posedge ref_clk);
    check8({7'h0, transfer_done_flag}, 8'h01);
    flag_clear <= 1'b1;
    @(posedge ref_clk);
    flag_clear <= 1'b0;
    @(posedge ref_clk);
    check8({7'h0, transfer_done_flag}, 8'h00);
  endtask

  // Core clock, 4 ns.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Reader stalls at random so the two-entry buffer really holds words.
  always @(posedge ref_clk) begin
    rx_ready <= drain & 1'($urandom);
    if (rst_n && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check8(rx_data, ~rx_data);
      end else begin
        note = exp_q.pop_front();
        check8(rx_data & note[15:8], note[7:0]);
      end
    end
  end

  // Watchdog, well beyond the expected run of about 4 us.
  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    {rst_n, serial_unit_enable, first_bit_select, wr_valid, flag_clear} = 5'h00;
    wr_data = 8'h00;
    drain = 1'b1;
    void'($urandom(21));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    send(8'h5a, 1'b0);
    serial_unit_enable <= 1'b1;
    repeat (100) @(posedge ref_clk);
    check8({6'h0, busy, transfer_done_flag}, 8'h00);
    // Order is only changed between transfers.
    for (int i = 0; i < 12; i++) begin
      first_bit_select <= i[0];
      xfer(i < 4 ? {i[1], 6'h00, ~i[1]} : 8'($urandom));
    end
    wait_empty();
    // Fill the buffer with the reader stalled; a full buffer refuses starts.
    drain <= 1'b0;
    xfer(8'h3c);
    xfer(8'hc3);
    check8({7'h0, wr_ready}, 8'h00);
    send(8'h77, 1'b0);
    drain <= 1'b1;
    wait_empty();
    repeat (100) @(posedge ref_clk);
    finish_test();
  end
endmodule
`default_nettype wire
